//--- rtl/pege_params.svh
// offsets, field positions, reset values and decode constants of the port e block
`ifndef PEGE_PARAMS_SVH
`define PEGE_PARAMS_SVH

// apb byte addresses, one aligned word each
`define PEGE_OFS_PIN_LEVELS   8'h00
`define PEGE_OFS_OUT_LATCH    8'h04
`define PEGE_OFS_DIR_STATUS   8'h08
`define PEGE_OFS_ANALOG_CFG   8'h0C

// direction and slave status field positions
`define PEGE_BIT_IN_FULL      7
`define PEGE_BIT_OUT_FULL     6
`define PEGE_BIT_IN_OVF       5
`define PEGE_BIT_MODE         4
`define PEGE_BIT_PIN3         3

// reset values
`define PEGE_RST_DIR          3'h7
`define PEGE_RST_LATCH        3'h0
`define PEGE_RST_ANALOG_CFG   6'h00

// analog field values at or above this make the three lower pins digital
`define PEGE_ACFG_DIGITAL_MIN 4'hA

`endif

//--- rtl/pege_pin.sv
// one bidirectional lower pin of port e with analog sharing
`timescale 1ns/100ps
`default_nettype none

module pege_pin
(
	input  wire logic i_dir,
	input  wire logic i_lat,
	input  wire logic i_analog,
	input  wire logic i_pad_in,
	output logic      o_oe,
	output logic      o_out,
	output logic      o_din
);

	// direction still wins while analog, software keeps such pins as inputs
	assign o_oe  = ~i_dir;
	assign o_out = i_lat;
	// analog reads zero, input buffer off
	assign o_din = i_analog ? 1'b0 : i_pad_in;

endmodule : pege_pin

`default_nettype wire

//--- rtl/pege_pkg.sv
// types shared by the port e block and its helpers
package pege_pkg;

	// active-low strobes of the external processor as seen on the lower pins
	typedef struct packed {
		logic cs_n;
		logic wr_n;
		logic rd_n;
	} pege_strobe_t;

	// events of the slave port, one-cycle pulses except rd_active
	typedef struct packed {
		logic wr_end;
		logic rd_start;
		logic rd_end;
		logic rd_active;
	} pege_slave_evt_t;

	// strobe tracker states, one bit apart from idle
	typedef enum logic [1:0] {
		PEGE_IDLE  = 2'h0,
		PEGE_WRITE = 2'h1,
		PEGE_READ  = 2'h2
	} pege_state_t;

endpackage : pege_pkg

//--- rtl/pege_strobe.sv
// tracks read and write strobes of the external processor
`timescale 1ns/100ps
`default_nettype none

module pege_strobe
	import pege_pkg::*;
(
	input  wire logic          i_clk,
	input  wire logic          i_srst,
	input  wire logic          i_enable,
	input  wire pege_strobe_t  i_strobe,
	output pege_slave_evt_t    o_evt
);

	pege_state_t     state_q;
	pege_state_t     state_d;
	pege_slave_evt_t evt_d;
	pege_slave_evt_t evt_q;

	wire wr_low = ~i_strobe.cs_n & ~i_strobe.wr_n;
	wire rd_low = ~i_strobe.cs_n & ~i_strobe.rd_n;

	// write frame spans both low, ends when either rises; a disabled port drops the frame silently
	always_comb
	begin
		state_d = state_q;
		evt_d   = '0;
		case (state_q)
			PEGE_IDLE:
			begin
				if (i_enable && wr_low)
					state_d = PEGE_WRITE;
				else if (i_enable && rd_low)
				begin
					state_d        = PEGE_READ;
					evt_d.rd_start = 1'b1;
				end
			end
			PEGE_WRITE:
			begin
				if (!i_enable)
					state_d = PEGE_IDLE;
				else if (!wr_low)
				begin
					state_d      = PEGE_IDLE;
					evt_d.wr_end = 1'b1;
				end
			end
			PEGE_READ:
			begin
				if (!i_enable)
					state_d = PEGE_IDLE;
				else if (!rd_low)
				begin
					state_d      = PEGE_IDLE;
					evt_d.rd_end = 1'b1;
				end
			end
			default:
				state_d = PEGE_IDLE;
		endcase
		evt_d.rd_active = (state_d == PEGE_READ);
	end

	// events leave from flops so consumers see clean pulses
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			state_q <= PEGE_IDLE;
			evt_q   <= '0;
		end
		else
		begin
			state_q <= state_d;
			evt_q   <= evt_d;
		end
	end

	assign o_evt = evt_q;

endmodule : pege_strobe

`default_nettype wire

//--- rtl/pege_top.sv
// port e general purpose pins with slave port strobes, apb register slave
`timescale 1ns/100ps
`default_nettype none
`include "pege_params.svh"

module pege_top
	import pege_pkg::*;
#(
	parameter bit LARGE_PKG  = 1'b1,
	parameter int LOWER_PINS = 3
)
(
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// lower pins, four signals each
	input  wire logic [2:0]  i_port_pin,
	output logic      [2:0]  o_port_pin,
	output logic      [2:0]  o_port_pin_oe,
	output logic      [2:0]  o_analog_sel,
	// input only pin and its configuration
	input  wire logic        i_input_only_pin3,
	input  wire logic        i_master_clear_pin_enable_cfg,
	output logic             o_external_master_clear_n,
	// neighbouring blocks
	input  wire logic        i_pwm_multi_output,
	input  wire logic        i_cpu_slave_data_rd,
	input  wire logic        i_cpu_slave_data_wr,
	output logic             o_slave_port_interrupt_flag,
	output logic             o_slave_data_capture,
	output logic             o_slave_data_drive,
	output logic             o_slave_port_active
);

	// the pin loop and strobe mapping are written for exactly three lower pins
	if (LOWER_PINS != 3)
	begin : g_bad_pins
		$error("pege_top serves exactly three lower pins");
	end

	// register state: latch, direction and mode first, then the hardware-set flags, the analog field and the read data
	// only three latch and direction bits exist; the upper latch bits read zero, the upper status bits are separate flops
	logic [2:0]  lat_q;
	logic [2:0]  lat_d;
	logic [2:0]  dir_q;
	logic [2:0]  dir_d;
	logic        mode_q;
	logic        mode_d;
	// buffer status: in full and overflow set by strobe events and cleared from the cpu side, out full the reverse
	logic        in_full_q;
	logic        in_full_d;
	logic        out_full_q;
	logic        out_full_d;
	logic        in_ovf_q;
	logic        in_ovf_d;
	// analog field in [3:0], two stored reference bits in [5:4]
	logic [5:0]  acfg_q;
	logic [5:0]  acfg_d;
	// read data is held in a register so o_prdata leaves a flop
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;

	// apb decode: a read's setup phase loads the read register, a write commits at the access edge
	// only the address picks the target; data bits above the low byte are ignored
	wire setup_rd  = i_psel & ~i_penable & ~i_pwrite;
	wire access    = i_psel & i_penable;
	// one aligned word per register, exact byte address match
	wire hit_pin   = (i_paddr == `PEGE_OFS_PIN_LEVELS);
	wire hit_lat   = (i_paddr == `PEGE_OFS_OUT_LATCH);
	wire hit_dir   = (i_paddr == `PEGE_OFS_DIR_STATUS);
	wire hit_acfg  = (i_paddr == `PEGE_OFS_ANALOG_CFG);
	wire hit_any   = hit_pin | hit_lat | hit_dir | hit_acfg;
	wire wr_en     = access & i_pwrite & hit_any;
	// writes to the pin register land in the latch, as a clear of the port does
	wire wr_lat    = wr_en & (hit_pin | hit_lat) & LARGE_PKG;
	wire wr_dir    = wr_en & hit_dir & LARGE_PKG;
	wire wr_acfg   = wr_en & hit_acfg;

	// zero wait states; unmapped addresses finish with an error and no effect
	assign o_pready  = 1'b1;
	assign o_pslverr = access & ~hit_any;

	// analog selection: one field value switches all three lower pins together
	// values below the digital threshold keep the pins analog, which is also the reset state
	// analog mode reaches each pin cell, which zeroes its port bit
	wire [3:0] acfg_field  = acfg_q[3:0];
	wire       pins_analog = (acfg_field < `PEGE_ACFG_DIGITAL_MIN);
	wire [2:0] analog      = {3{pins_analog & LARGE_PKG}};
	// per-pin views from the pin cells
	wire [2:0] pin_din;
	wire [2:0] pin_oe;
	wire [2:0] pin_out;

	// three independent lower pins on the large package
	// each pin cell is pure wiring; all state stays in the register flops below
	for (genvar gi = 0; gi < LOWER_PINS; gi++)
	begin : g_pin
		pege_pin u_pin
		(
			.i_dir    (dir_q[gi]),
			.i_lat    (lat_q[gi]),
			.i_analog (analog[gi]),
			.i_pad_in (i_port_pin[gi]),
			.o_oe     (pin_oe[gi]),
			.o_out    (pin_out[gi]),
			.o_din    (pin_din[gi])
		);
	end

	// small package has no lower pins, drivers stay off
	// analog selection is gated the same way, so those outputs stay low too
	assign o_port_pin_oe = LARGE_PKG ? pin_oe : 3'h0;
	assign o_port_pin    = LARGE_PKG ? pin_out : 3'h0;
	assign o_analog_sel  = analog;

	// input only pin: no direction or latch bit belongs to it
	// the reset output bypasses the clock so a stopped clock cannot hold off a reset
	// pin three either port input or external master clear
	// digital input only while master clear is configured off
	wire pin3_din = ~i_master_clear_pin_enable_cfg & i_input_only_pin3;
	assign o_external_master_clear_n = i_master_clear_pin_enable_cfg ? i_input_only_pin3 : 1'b1;

	// slave port strobes: the lower pins become the external processor's control inputs
	pege_strobe_t    strobe;
	pege_slave_evt_t evt;

	// multi-output pwm overrides slave mode
	// the mode bit stays set meanwhile, so the port resumes when the pwm unit lets go
	wire slave_en = mode_q & ~i_pwm_multi_output & LARGE_PKG;

	// strobes ride the raw ttl pin levels, not the gated port bits
	// the strobes are only meaningful if software left the pins as inputs
	assign strobe.rd_n = i_port_pin[0];
	assign strobe.wr_n = i_port_pin[1];
	assign strobe.cs_n = i_port_pin[2];

	// the tracker sees the strobes only while the port is enabled
	pege_strobe u_strobe
	(
		.i_clk    (i_clk),
		.i_srst   (i_srst),
		.i_enable (slave_en),
		.i_strobe (strobe),
		.o_evt    (evt)
	);

	// the capture and drive outputs tell the data port when to latch or drive its word
	assign o_slave_port_active         = slave_en;
	// end of either frame raises the port event
	assign o_slave_port_interrupt_flag = evt.wr_end | evt.rd_end;
	assign o_slave_data_capture        = evt.wr_end;
	assign o_slave_data_drive          = evt.rd_active;

	// status flags: in full and overflow are set by a strobe event and cleared from the cpu side, out full the reverse
	// the hardware set of in full and overflow wins a same-cycle clear, so no event is lost; out full's read-start clear wins
	// full on write end; hardware set wins over the cpu read
	// write end sets the full flag
	assign in_full_d = evt.wr_end | (in_full_q & ~i_cpu_slave_data_rd);

	// cpu write marks the word pending until an external read starts
	// a cpu write while a read is active goes straight out and leaves it clear
	assign out_full_d = (i_cpu_slave_data_wr & ~evt.rd_active & ~evt.rd_start)
	                  | (out_full_q & ~evt.rd_start);

	// overflow sticks until software writes zero; the set wins a same-cycle clear
	// a cpu read in the same cycle as the write end frees the buffer, so that is no overflow
	wire in_ovf_set = evt.wr_end & in_full_q & ~i_cpu_slave_data_rd;
	assign in_ovf_d = in_ovf_set | (wr_dir ? i_pwdata[`PEGE_BIT_IN_OVF] : in_ovf_q);

	// software writable fields, committed only at the access edge of a write
	// latch written from bus, never from pins
	assign lat_d  = wr_lat ? i_pwdata[2:0] : lat_q;
	assign mode_d = wr_dir ? i_pwdata[`PEGE_BIT_MODE] : mode_q;
	// the full flags and bit three take no write data
	assign dir_d  = wr_dir ? i_pwdata[2:0] : dir_q;
	// the two reference bits above the field are stored for software only
	assign acfg_d = wr_acfg ? i_pwdata[5:0] : acfg_q;

	// read data, captured in the setup phase
	// capturing early lets the access phase answer at once with a settled word
	// bits seven to four zero, bit three only without master clear
	wire [7:0] rd_pin  = {4'h0, pin3_din, (LARGE_PKG ? pin_din : 3'h0)};
	wire [7:0] rd_lat  = {5'h00, lat_q};
	// the small package has no direction or status bits, so that word reads zero
	wire [7:0] rd_dir  = LARGE_PKG ? {in_full_q, out_full_q, in_ovf_q, mode_q, 1'b0, dir_q} : 8'h00;
	wire [7:0] rd_acfg = {2'h0, acfg_q};

	// unmapped addresses read as zero beside the error response
	wire [7:0] rd_sel = hit_pin  ? rd_pin  :
	                    hit_lat  ? rd_lat  :
	                    hit_dir  ? rd_dir  :
	                    hit_acfg ? rd_acfg : 8'h00;

	// the read register holds its word until the next read setup
	assign prdata_d = setup_rd ? {24'h000000, rd_sel} : prdata_q;
	assign o_prdata = prdata_q;

	// flops, one short process per field
	// reset puts the lower pins analog
	// the analog field clears, which is below the digital threshold
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			acfg_q <= `PEGE_RST_ANALOG_CFG;
		end
		else
		begin
			acfg_q <= acfg_d;
		end
	end

	// reset leaves the lower pins as inputs
	// all drivers off until software clears a direction bit
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			dir_q <= `PEGE_RST_DIR;
		end
		else
		begin
			dir_q <= dir_d;
		end
	end

	// output latch, cleared at reset
	// a later direction change then drives known zeros rather than junk
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			lat_q <= `PEGE_RST_LATCH;
		end
		else
		begin
			lat_q <= lat_d;
		end
	end

	// slave port mode resets to general purpose i/o
	// strobes on the lower pins are ignored until software sets it
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			mode_q <= 1'b0;
		end
		else
		begin
			mode_q <= mode_d;
		end
	end

	// read register
	// loaded only in a read setup phase, so writes never disturb it
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			prdata_q <= 32'h00000000;
		end
		else
		begin
			prdata_q <= prdata_d;
		end
	end

	// input buffer full flag
	// set by the end of an external write, cleared by the cpu read pulse
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			in_full_q <= 1'b0;
		end
		else
		begin
			in_full_q <= in_full_d;
		end
	end

	// output buffer full flag
	// set by the cpu write pulse, cleared when an external read starts
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			out_full_q <= 1'b0;
		end
		else
		begin
			out_full_q <= out_full_d;
		end
	end

	// input overflow flag
	// sticky: only a software write of zero, or a reset, clears it
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			in_ovf_q <= 1'b0;
		end
		else
		begin
			in_ovf_q <= in_ovf_d;
		end
	end

endmodule : pege_top

`default_nettype wire

//--- testbench/pege_far.sv
// lower pin pads as the board and external processor see them
`timescale 1ns/100ps
`default_nettype none

module pege_far
(
	input  wire logic       i_clk,
	input  wire logic [2:0] i_out,
	input  wire logic [2:0] i_oe,
	output logic      [2:0] o_pad
);
	// far side level, strobes idle high as on a pulled-up board
	logic [2:0] ext_q = 3'h7;

	// a driven pin shows the latch, a floating one the far side
	assign o_pad = (i_oe & i_out) | (~i_oe & ext_q);

	task automatic drive(input logic [2:0] v);
		@(posedge i_clk);
		ext_q <= v;
	endtask : drive

	// frame with select and one strobe low, then idle edges
	task automatic frame(input logic [2:0] lo, input int len);
		@(posedge i_clk);
		ext_q <= lo;
		repeat (len) @(posedge i_clk);
		ext_q <= 3'h7;
		repeat (3) @(posedge i_clk);
	endtask : frame
endmodule : pege_far

`default_nettype wire

//--- testbench/pege_top_props.sv
// concurrent checks on the port e block ports
`timescale 1ns/100ps
`default_nettype none

module pege_top_props
(
	input wire logic        i_clk,
	input wire logic        i_srst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [7:0]  i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic        o_pslverr,
	input wire logic [2:0]  i_port_pin,
	input wire logic [2:0]  o_port_pin,
	input wire logic [2:0]  o_port_pin_oe,
	input wire logic [2:0]  o_analog_sel,
	input wire logic        i_input_only_pin3,
	input wire logic        i_master_clear_pin_enable_cfg,
	input wire logic        o_external_master_clear_n,
	input wire logic        i_pwm_multi_output,
	input wire logic        o_slave_port_interrupt_flag,
	input wire logic        o_slave_data_capture,
	input wire logic        o_slave_data_drive,
	input wire logic        o_slave_port_active
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);

	// write strobe and address map of the access cycle
	logic wr_w;
	logic map_w;
	assign wr_w = i_psel && i_penable && i_pwrite;
	assign map_w = i_paddr inside {8'h00, 8'h04, 8'h08, 8'h0C};

	a_reset_state: assert property ($past(i_srst) |-> o_port_pin_oe == 3'h0 && o_analog_sel == 3'h7)
		else $error("pins not analog inputs after reset");
	a_dir_drive: assert property (wr_w && i_paddr == 8'h08 |=> o_port_pin_oe == ~$past(i_pwdata[2:0]))
		else $error("driver enables do not follow direction");
	a_latch_drive: assert property (wr_w && i_paddr inside {8'h00, 8'h04} |=> o_port_pin == $past(i_pwdata[2:0]))
		else $error("pin drive does not follow latch");
	a_analog_sel: assert property (wr_w && i_paddr == 8'h0C |=> o_analog_sel == {3{$past(i_pwdata[3:0]) < 4'hA}})
		else $error("analog selection wrong");
	a_clear_pin: assert property (o_external_master_clear_n == (i_master_clear_pin_enable_cfg ? i_input_only_pin3 : 1'h1))
		else $error("master clear routing wrong");
	a_unmapped_err: assert property (i_psel && i_penable |-> o_pslverr == !map_w)
		else $error("error response wrong");
	a_pwm_block: assert property (i_pwm_multi_output |-> !o_slave_port_active)
		else $error("slave port active beside multi output pwm");
	a_end_event: assert property (o_slave_data_capture |-> o_slave_port_interrupt_flag ##1 !o_slave_data_capture)
		else $error("write end event wrong");
	a_read_start: assert property ($rose(o_slave_data_drive) |-> ($past(i_port_pin) & 3'h5) == 3'h0)
		else $error("read drive without select and read low");

	c_capture: cover property (o_slave_data_capture);
	c_drive: cover property ($rose(o_slave_data_drive));
	c_error: cover property (o_pslverr);
endmodule : pege_top_props

bind pege_top pege_top_props u_props
(
	.i_clk(i_clk),
	.i_srst(i_srst),
	.i_psel(i_psel),
	.i_penable(i_penable),
	.i_pwrite(i_pwrite),
	.i_paddr(i_paddr),
	.i_pwdata(i_pwdata),
	.o_pslverr(o_pslverr),
	.i_port_pin(i_port_pin),
	.o_port_pin(o_port_pin),
	.o_port_pin_oe(o_port_pin_oe),
	.o_analog_sel(o_analog_sel),
	.i_input_only_pin3(i_input_only_pin3),
	.i_master_clear_pin_enable_cfg(i_master_clear_pin_enable_cfg),
	.o_external_master_clear_n(o_external_master_clear_n),
	.i_pwm_multi_output(i_pwm_multi_output),
	.o_slave_port_interrupt_flag(o_slave_port_interrupt_flag),
	.o_slave_data_capture(o_slave_data_capture),
	.o_slave_data_drive(o_slave_data_drive),
	.o_slave_port_active(o_slave_port_active)
);

`default_nettype wire

//--- testbench/pege_top_test.sv
// self-checking bench of the port e block
`timescale 1ns/100ps
`default_nettype none

module pege_top_test;
	logic        clk = 1'h0;
	logic        srst = 1'h1;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        pin3 = 1'h0;
	logic        cfg = 1'h0;
	logic        pwm = 1'h0;
	logic        cpu_rd = 1'h0;
	logic        cpu_wr = 1'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, err_q, external_master_clear_input_n, irq, cap, drv, act;
	logic [2:0]  pad, out, oe, asel;
	int          error_cnt = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          cap_n = 0;
	int          irq_n = 0;
	int          drv_n = 0;

	pege_top dut
	(
		.i_clk(clk),
		.i_srst(srst),
		.i_psel(psel),
		.i_penable(penable),
		.i_pwrite(pwrite),
		.i_paddr(paddr),
		.i_pwdata(pwdata),
		.o_prdata(prdata),
		.o_pready(pready),
		.o_pslverr(pslverr),
		.i_port_pin(pad),
		.o_port_pin(out),
		.o_port_pin_oe(oe),
		.o_analog_sel(asel),
		.i_input_only_pin3(pin3),
		.i_master_clear_pin_enable_cfg(cfg),
		.o_external_master_clear_n(external_master_clear_input_n),
		.i_pwm_multi_output(pwm),
		.i_cpu_slave_data_rd(cpu_rd),
		.i_cpu_slave_data_wr(cpu_wr),
		.o_slave_port_interrupt_flag(irq),
		.o_slave_data_capture(cap),
		.o_slave_data_drive(drv),
		.o_slave_port_active(act)
	);

	pege_far far
	(
		.i_clk(clk),
		.i_out(out),
		.i_oe(oe),
		.o_pad(pad)
	);

	initial
	begin
		forever #20 clk = ~clk;
	end

	// event counters, and a cycle ceiling that cuts a hang short
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		cap_n <= cap_n + int'(cap === 1'h1);
		irq_n <= irq_n + int'(irq === 1'h1);
		drv_n <= drv_n + int'(drv === 1'h1);
		if (cyc == 3000)
		begin
			error_cnt++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	// apb transfer, held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1)
			@(posedge clk);
		r = prdata;
		err_q = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'h1, a, d, r);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		apb(1'h0, a, 32'h0, r);
		chk(r, exp, "register read");
	endtask : rd

	task automatic cpu_pulse(input logic w);
		@(posedge clk);
		cpu_wr <= w;
		cpu_rd <= !w;
		@(posedge clk);
		cpu_wr <= 1'h0;
		cpu_rd <= 1'h0;
	endtask : cpu_pulse

	task automatic t_reset();
		chk(32'(oe), 32'h0, "drivers after reset");
		chk(32'(asel), 32'h7, "analog after reset");
		rd(8'h08, 32'h07);
		rd(8'h04, 32'h00);
		rd(8'h00, 32'h00);
		$display("test reset done");
	endtask : t_reset

	task automatic t_gpio();
		wr(8'h0C, 32'h0F);
		far.drive(3'h5);
		rd(8'h00, 32'h05);
		wr(8'h04, 32'h06);
		wr(8'h08, 32'hCA);
		rd(8'h08, 32'h02);
		chk(32'(oe), 32'h5, "driver enables");
		rd(8'h04, 32'h06);
		rd(8'h00, 32'h04);
		wr(8'h0C, 32'h00);
		chk(32'(oe), 32'h5, "drivers while analog");
		chk(32'(out), 32'h6, "drive while analog");
		rd(8'h00, 32'h00);
		wr(8'h08, 32'h07);
		$display("test gpio done");
	endtask : t_gpio

	task automatic t_pin3();
		wr(8'h0C, 32'h0F);
		far.drive(3'h0);
		pin3 <= 1'h1;
		rd(8'h00, 32'h08);
		chk(32'(external_master_clear_input_n), 32'h1, "clear idle");
		cfg <= 1'h1;
		rd(8'h00, 32'h00);
		pin3 <= 1'h0;
		@(posedge clk);
		chk(32'(external_master_clear_input_n), 32'h0, "clear follows pin");
		cfg <= 1'h0;
		$display("test pin3 done");
	endtask : t_pin3

	task automatic t_slave();
		far.drive(3'h7);
		wr(8'h08, 32'h17);
		far.frame(3'h1, 3);
		chk(32'(cap_n), 32'h1, "write capture");
		chk(32'(act), 32'h1, "slave port enabled");
		rd(8'h08, 32'h97);
		far.frame(3'h1, 2);
		rd(8'h08, 32'hB7);
		wr(8'h08, 32'h17);
		rd(8'h08, 32'h97);
		cpu_pulse(1'h0);
		rd(8'h08, 32'h17);
		cpu_pulse(1'h1);
		rd(8'h08, 32'h57);
		far.frame(3'h2, 3);
		rd(8'h08, 32'h17);
		chk(32'(drv_n), 32'h3, "read drive cycles");
		chk(32'(irq_n), 32'h3, "port events");
		pwm <= 1'h1;
		far.frame(3'h1, 3);
		chk(32'(cap_n), 32'h2, "blocked by pwm");
		chk(32'(act), 32'h0, "slave port blocked");
		rd(8'h10, 32'h0);
		chk(32'(err_q), 32'h1, "unmapped error");
		$display("test slave done");
	endtask : t_slave

	initial
	begin
		repeat (16) @(posedge clk);
		srst <= 1'h0;
		t_reset();
		t_gpio();
		t_pin3();
		t_slave();
		close_out();
	end
endmodule : pege_top_test

`default_nettype wire
